// ---- design/usart_line_mode.sv ----
// Summary of operation
// - inhibit set: no NACK, set flag
// - clear nack flag command clears flag
// - inhibited bad char stored, no ready
// - NACKed char resent up to limit
// - count reaching limit sets repeat flag
// - acknowledge stops repeats, clears counter
// - clear repeat command clears repeat flag
// - NACK limit reached: accept, ack, flag
// - T=1 parity generated, checked, flagged
// - mode 0x8 enables infrared path
// - zero bit is 3/16 bit pulse
// - 8-bit filter counts after falling edge
// - filter expiry drives receiver low
// - RS485 drives RTS as not empty
// - modem mode drives DTR, RTS, monitors
// - terminal ready commands force DTR
// - input change sets flag, read clears
// - CTS high stops after current char
// - echo forwards receive pin to transmit
// - local loopback: tx feeds rx, pin high
// - remote loopback: pin routed, engines off
// - T=0 is 0x4, T=1 is 0x5
// - T=0 parity error NACKs guard time
`timescale 1ns/100ps
`default_nettype none
module usart_line_mode (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_pin,
    input wire logic cts_pin,
    input wire logic dcd_pin,
    input wire logic dsr_pin,
    input wire logic ri_pin,
    output logic txd_o,
    output logic txd_oe,
    output logic rts_o,
    output logic dtr_o,
    input wire logic bit_tick,
    input wire logic tx_serial,
    input wire logic tx_busy,
    input wire logic tx_empty,
    input wire logic [7:0] tx_char,
    input wire logic tx_guard_sample,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_bit,
    output logic rx_serial,
    output logic tx_enable,
    output logic rx_enable,
    output logic tx_repeat,
    output logic tx_parity
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: level moves once stages two and three agree
    logic [2:0] sync_reg [line_mode_pkg::NPINS];
    logic [line_mode_pkg::NPINS-1:0] lvl_reg;
    logic [line_mode_pkg::NPINS-1:0] lvl_prev_reg;
    logic [line_mode_pkg::NPINS-1:0] pins;
    assign pins = {ri_pin, dsr_pin, dcd_pin, cts_pin, rxd_pin};

    genvar gi;
    generate
        for (gi = 0; gi < line_mode_pkg::NPINS; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_reg[gi] <= 3'b111;
                    lvl_reg[gi] <= 1'b1;
                    lvl_prev_reg[gi] <= 1'b1;
                end else begin
                    sync_reg[gi] <= {sync_reg[gi][1:0], pins[gi]};
                    if (sync_reg[gi][1] == sync_reg[gi][2]) begin
                        lvl_reg[gi] <= sync_reg[gi][2];
                    end
                    lvl_prev_reg[gi] <= lvl_reg[gi];
                end
            end
        end
    endgenerate

    logic rxd_lvl;
    logic [3:0] mdm_change;
    assign rxd_lvl = lvl_reg[line_mode_pkg::PIN_RXD];
    assign mdm_change = lvl_reg[4:1] ^ lvl_prev_reg[4:1];

    ////////////////////////////////////////////////////////////////////
    // apb slave, no wait state: pready rises in the first access cycle
    line_mode_pkg::mode_t mode_reg;
    logic [10:0] ratio_reg;
    logic [7:0] irfilt_reg;
    logic [7:0] hold_reg;
    logic [31:0] status;
    logic [31:0] rdata;
    logic hit;
    logic setup;
    logic access;
    logic wr_ctl;
    logic rd_status;
    logic rd_hold;
    logic [31:0] cmd;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr_ctl = access & pwrite &
        (paddr == line_mode_pkg::ADDR_CONTROL);
    assign rd_status = access & ~pwrite &
        (paddr == line_mode_pkg::ADDR_STATUS);
    assign rd_hold = access & ~pwrite &
        (paddr == line_mode_pkg::ADDR_HOLD);
    assign cmd = wr_ctl ? pwdata : 32'h0000_0000;

    always_comb begin
        hit = 1'b1;
        case (paddr)
            line_mode_pkg::ADDR_CONTROL: rdata = 32'h0000_0000;
            line_mode_pkg::ADDR_MODE: rdata = {21'h0, mode_reg};
            line_mode_pkg::ADDR_STATUS: rdata = status;
            line_mode_pkg::ADDR_HOLD: rdata = {24'h0, hold_reg};
            line_mode_pkg::ADDR_RATIO: rdata = {21'h0, ratio_reg};
            line_mode_pkg::ADDR_IRFILT: rdata = {24'h0, irfilt_reg};
            default: begin
                rdata = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= '0;
            ratio_reg <= line_mode_pkg::RATIO_RESET;
            irfilt_reg <= 8'h00;
        end else if (access & pwrite) begin
            case (paddr)
                line_mode_pkg::ADDR_MODE: mode_reg <= pwdata[10:0];
                line_mode_pkg::ADDR_RATIO: ratio_reg <= pwdata[10:0];
                line_mode_pkg::ADDR_IRFILT: irfilt_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode decode
    logic iso_t0;
    logic iso;
    logic ir;
    logic normal;
    assign iso_t0 = mode_reg.line == line_mode_pkg::LINE_ISO_T0;
    assign iso = iso_t0 |
        (mode_reg.line == line_mode_pkg::LINE_ISO_T1);
    assign ir = mode_reg.line == line_mode_pkg::LINE_IR;
    assign normal = mode_reg.chmode == line_mode_pkg::CH_NORMAL;

    ////////////////////////////////////////////////////////////////////
    // receive side: parity, nack, holding register
    logic receive_ready_flag_reg;
    logic parity_reg;
    logic nack_flag_reg;
    logic repeat_flag_reg;
    logic [2:0] nack_cnt_reg;
    logic nack_pend_reg;
    logic nack_drive_reg;
    logic bad;
    logic bad_t0;
    logic lim_hit;
    logic nack_send;
    logic accept;
    logic rep_set;

    assign bad = rx_char_valid & ((^rx_char) ^ rx_parity_bit);
    assign bad_t0 = bad & iso_t0;
    assign lim_hit = mode_reg.limit_successive_nack &
        (mode_reg.max_iter != 3'd0) & (nack_cnt_reg == mode_reg.max_iter);
    assign nack_send = bad_t0 & ~mode_reg.nack_inhibit & ~lim_hit;
    assign accept = rx_char_valid & ~nack_send;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 8'h00;
            receive_ready_flag_reg <= 1'b0;
        end else begin
            if (accept) begin
                hold_reg <= rx_char;
            end
            if (accept & ~(bad_t0 & mode_reg.nack_inhibit)) begin
                receive_ready_flag_reg <= 1'b1;
            end else if (rd_hold) begin
                receive_ready_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_reg <= 1'b0;
            nack_flag_reg <= 1'b0;
        end else begin
            if (bad) begin
                parity_reg <= 1'b1;
            end else if (cmd[line_mode_pkg::CMD_CLR_PARITY]) begin
                parity_reg <= 1'b0;
            end
            if (bad_t0 & mode_reg.nack_inhibit) begin
                nack_flag_reg <= 1'b1;
            end else if (cmd[line_mode_pkg::CMD_CLR_NACK]) begin
                nack_flag_reg <= 1'b0;
            end
        end
    end

    // nack occupies the bit period after the next bit tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nack_cnt_reg <= 3'd0;
            nack_pend_reg <= 1'b0;
            nack_drive_reg <= 1'b0;
        end else begin
            if (nack_send) begin
                nack_cnt_reg <= nack_cnt_reg + 3'd1;
                nack_pend_reg <= 1'b1;
            end else if (accept) begin
                nack_cnt_reg <= 3'd0;
            end
            if (bit_tick) begin
                nack_drive_reg <= nack_pend_reg & ~nack_send;
                if (!nack_send) begin
                    nack_pend_reg <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit repetition on nack seen in the guard time
    logic [2:0] rep_cnt_reg;
    logic nack_seen;
    logic can_rep;
    assign nack_seen = tx_guard_sample & iso_t0 & ~rxd_lvl;
    assign can_rep = mode_reg.max_iter != 3'd0 &&
        rep_cnt_reg < mode_reg.max_iter;
    assign rep_set = (bad_t0 & lim_hit) |
        (nack_seen & can_rep &&
        rep_cnt_reg + 3'd1 == mode_reg.max_iter);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_cnt_reg <= 3'd0;
            tx_repeat <= 1'b0;
            repeat_flag_reg <= 1'b0;
        end else begin
            tx_repeat <= nack_seen & can_rep;
            if (nack_seen & can_rep) begin
                rep_cnt_reg <= rep_cnt_reg + 3'd1;
            end else if (tx_guard_sample) begin
                rep_cnt_reg <= 3'd0;
            end
            if (rep_set) begin
                repeat_flag_reg <= 1'b1;
            end else if (cmd[line_mode_pkg::CMD_CLR_REPEAT]) begin
                repeat_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // modem lines
    logic [3:0] chg_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_reg <= 4'h0;
            dtr_o <= 1'b1;
            rts_o <= 1'b1;
            tx_enable <= 1'b1;
            tx_parity <= 1'b0;
        end else begin
            chg_reg <= mdm_change | (rd_status ? 4'h0 : chg_reg);
            if (cmd[line_mode_pkg::CMD_DTR_OFF]) begin
                dtr_o <= 1'b1;
            end else if (cmd[line_mode_pkg::CMD_DTR_ON]) begin
                dtr_o <= 1'b0;
            end
            if (mode_reg.line == line_mode_pkg::LINE_RS485) begin
                rts_o <= ~tx_empty;
            end else begin
                rts_o <= mode_reg.line != line_mode_pkg::LINE_MODEM;
            end
            if (mode_reg.chmode == line_mode_pkg::CH_REMOTE) begin
                tx_enable <= 1'b0;
            end else if (mode_reg.line == line_mode_pkg::LINE_MODEM &&
                    lvl_reg[line_mode_pkg::PIN_CTS]) begin
                tx_enable <= tx_enable & tx_busy;
            end else begin
                tx_enable <= 1'b1;
            end
            tx_parity <= ^tx_char;
        end
    end

    assign status = {16'h0, lvl_reg[4:1], chg_reg, 3'h0, tx_empty,
        repeat_flag_reg, nack_flag_reg, parity_reg, receive_ready_flag_reg};

    ////////////////////////////////////////////////////////////////////
    // infrared modulator and demodulator
    logic [10:0] pulse_cnt_reg;
    logic [10:0] low_cnt_reg;
    logic [7:0] filt_reg;
    logic filt_run_reg;
    logic [10:0] pulse_len;
    logic [13:0] pulse_prod;
    logic ir_in;
    assign pulse_prod = {3'h0, ratio_reg} * 14'(line_mode_pkg::IR_PULSE_NUM);
    assign pulse_len = 11'(pulse_prod >> line_mode_pkg::IR_PULSE_SHIFT);
    assign ir_in = low_cnt_reg == 11'd0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_reg <= 11'd0;
        end else if (bit_tick & ~tx_serial) begin
            pulse_cnt_reg <= pulse_len;
        end else if (pulse_cnt_reg != 11'd0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 11'd1;
        end
    end

    // a rising edge resets the filter; expiry opens a bit-long low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_reg <= 8'h00;
            filt_run_reg <= 1'b0;
            low_cnt_reg <= 11'd0;
        end else begin
            if (rxd_lvl & ~lvl_prev_reg[line_mode_pkg::PIN_RXD]) begin
                filt_reg <= irfilt_reg;
                filt_run_reg <= 1'b0;
            end else if (~rxd_lvl & lvl_prev_reg[line_mode_pkg::PIN_RXD]) begin
                filt_reg <= irfilt_reg;
                filt_run_reg <= 1'b1;
            end else if (filt_run_reg) begin
                if (filt_reg == 8'h00) begin
                    filt_run_reg <= 1'b0;
                end else begin
                    filt_reg <= filt_reg - 8'h01;
                end
            end
            if (filt_run_reg && filt_reg == 8'h00) begin
                low_cnt_reg <= ratio_reg;
            end else if (low_cnt_reg != 11'd0) begin
                low_cnt_reg <= low_cnt_reg - 11'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // line routing by channel mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_o <= 1'b1;
            txd_oe <= 1'b1;
            rx_serial <= 1'b1;
            rx_enable <= 1'b1;
        end else begin
            rx_enable <= mode_reg.chmode != line_mode_pkg::CH_REMOTE;
            txd_oe <= ~iso | ~normal | tx_busy | nack_drive_reg;
            case (mode_reg.chmode)
                line_mode_pkg::CH_ECHO, line_mode_pkg::CH_REMOTE: begin
                    txd_o <= rxd_lvl;
                    rx_serial <= mode_reg.chmode == line_mode_pkg::CH_ECHO
                        ? rxd_lvl : 1'b1;
                end
                line_mode_pkg::CH_LOCAL: begin
                    txd_o <= 1'b1;
                    rx_serial <= tx_serial;
                end
                default: begin
                    if (ir) begin
                        txd_o <= pulse_cnt_reg != 11'd0;
                        rx_serial <= ir_in;
                    end else begin
                        txd_o <= tx_serial & ~(iso_t0 & nack_drive_reg);
                        rx_serial <= rxd_lvl;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence inhibited_bad_s;
        bad_t0 && mode_reg.nack_inhibit;
    endsequence

    nack_inhibit_a: assert property (inhibited_bad_s |=> nack_flag_reg
        && !nack_pend_reg) else $error("inhibit flag or nack wrong");
    clr_nack_a: assert property (cmd[line_mode_pkg::CMD_CLR_NACK] && !bad_t0
        |=> !nack_flag_reg) else $error("nack flag not cleared");
    hold_inhibit_a: assert property ((inhibited_bad_s and !receive_ready_flag_reg)
        |=> hold_reg == $past(rx_char) && !receive_ready_flag_reg)
        else $error("inhibited char handling wrong");
    repeat_a: assert property (nack_seen && can_rep |=> tx_repeat
        ##1 !tx_repeat) else $error("repeat pulse wrong");
    rep_limit_a: assert property (tx_repeat && rep_cnt_reg ==
        mode_reg.max_iter |-> repeat_flag_reg)
        else $error("repeat flag missing");
    ack_clear_a: assert property (tx_guard_sample && rxd_lvl
        |=> rep_cnt_reg == 3'd0) else $error("counter not cleared");
    lim_nack_a: assert property (bad_t0 && lim_hit
        && !mode_reg.nack_inhibit |=> repeat_flag_reg && receive_ready_flag_reg
        && nack_cnt_reg == 3'd0) else $error("limit accept wrong");
    rs485_rts_a: assert property (mode_reg.line == line_mode_pkg::LINE_RS485
        && $stable(mode_reg) |=> rts_o == !$past(tx_empty))
        else $error("rs485 rts wrong");
    chg_flag_a: assert property (mdm_change != 4'h0
        |=> (chg_reg & $past(mdm_change)) == $past(mdm_change))
        else $error("change flag lost");
    cts_hold_a: assert property (tx_enable && tx_busy && $stable(mode_reg)
        && mode_reg.chmode != line_mode_pkg::CH_REMOTE |=> tx_enable)
        else $error("char cut by cts");
    local_loop_a: assert property (mode_reg.chmode == line_mode_pkg::CH_LOCAL
        [*2] |-> txd_o && rx_serial == $past(tx_serial))
        else $error("local loopback wrong");
endmodule : usart_line_mode
`default_nettype wire

// ---- design/line_mode_pkg.sv ----
`default_nettype none
package line_mode_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_HOLD = 8'h0c;
    localparam logic [7:0] ADDR_RATIO = 8'h10;
    localparam logic [7:0] ADDR_IRFILT = 8'h14;
    // line mode select values
    localparam logic [3:0] LINE_RS485 = 4'h1;
    localparam logic [3:0] LINE_MODEM = 4'h3;
    localparam logic [3:0] LINE_ISO_T0 = 4'h4;
    localparam logic [3:0] LINE_ISO_T1 = 4'h5;
    localparam logic [3:0] LINE_IR = 4'h8;
    // control register command bits
    localparam int CMD_CLR_NACK = 0;
    localparam int CMD_CLR_REPEAT = 1;
    localparam int CMD_DTR_OFF = 2;
    localparam int CMD_DTR_ON = 3;
    localparam int CMD_CLR_PARITY = 4;
    // status bit positions
    localparam int ST_RECEIVE_READY_FLAG = 0;
    localparam int ST_PARITY = 1;
    localparam int ST_NACK = 2;
    localparam int ST_REPEAT = 3;
    localparam int ST_TRANSMITTER_EMPTY_FLAG = 4;
    localparam int ST_CHANGE = 8;
    localparam int ST_LEVEL = 12;
    // clock ratio reset value and infrared pulse fraction 3/16
    localparam logic [10:0] RATIO_RESET = 11'h174;
    localparam int IR_PULSE_NUM = 3;
    localparam int IR_PULSE_SHIFT = 4;
    // pin vector order
    localparam int PIN_RXD = 0;
    localparam int PIN_CTS = 1;
    localparam int NPINS = 5;

    typedef enum logic [1:0] {
        CH_NORMAL, CH_ECHO, CH_LOCAL, CH_REMOTE
    } chmode_t;

    typedef struct packed {
        logic [2:0] max_iter;
        logic limit_successive_nack;
        logic nack_inhibit;
        chmode_t chmode;
        logic [3:0] line;
    } mode_t;
endpackage : line_mode_pkg
`default_nettype wire

// ---- test/line_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// far side: card on the shared i/o line (pull-up), else separate pins
module line_partner (
    input wire logic txd_o,
    input wire logic txd_oe,
    input wire logic card_low,
    input wire logic shared,
    output logic rxd_pin
);
    // wired-and only on the card line; infrared and modem use own pins
    always_comb rxd_pin = !(card_low || (shared && txd_oe && !txd_o));
endmodule : line_partner
`default_nettype wire

// ---- test/tb_usart_line_mode.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_usart_line_mode;
    localparam logic [7:0] A_MODE = line_mode_pkg::ADDR_MODE;
    localparam logic [7:0] A_CTL = line_mode_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_ST = line_mode_pkg::ADDR_STATUS;
    // 3/16 of the 16-clock bit period written to the ratio register
    localparam int IR_PULSE = (16 * line_mode_pkg::IR_PULSE_NUM) >>
        line_mode_pkg::IR_PULSE_SHIFT;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, tx_char, rx_char, c;
    logic [31:0] pwdata, prdata;
    logic rxd_pin, cts_pin, dcd_pin, dsr_pin, ri_pin, card_low, seen, shared;
    logic txd_o, txd_oe, rts_o, dtr_o, bit_tick, tx_serial, tx_busy;
    logic tx_empty, tx_guard_sample, rx_char_valid, rx_parity_bit;
    logic rx_serial, tx_enable, rx_enable, tx_repeat, tx_parity;
    logic [64:0] expq[$];
    logic [64:0] e;
    int num_errors, cmp_count, k;

    usart_line_mode i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd_pin, .cts_pin,
        .dcd_pin, .dsr_pin, .ri_pin, .txd_o, .txd_oe, .rts_o, .dtr_o,
        .bit_tick, .tx_serial, .tx_busy, .tx_empty, .tx_char,
        .tx_guard_sample, .rx_char_valid, .rx_char, .rx_parity_bit,
        .rx_serial, .tx_enable, .rx_enable, .tx_repeat, .tx_parity);
    line_partner i_card (.txd_o, .txd_oe, .card_low, .shared, .rxd_pin);

    always #2 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // reads note {slverr, mask, data} for the monitor
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] m,
                       input logic err);
        int n;
        if (!w) expq.push_back({err, m, d & m});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0000_0000, 1'b0);
        cyc(1);
    endtask : wr

    task automatic mode(input logic [3:0] ln, input logic [1:0] ch,
                        input logic inh, input logic [2:0] it);
        wr(A_MODE, {21'h0, it, 1'b0, inh, ch, ln});
        cyc(6);
    endtask : mode

    task automatic pulse_tick;
        @(posedge pclk);
        bit_tick <= 1'b1;
        @(posedge pclk);
        bit_tick <= 1'b0;
    endtask : pulse_tick

    task automatic rxc(input logic [7:0] ch, input logic bad);
        @(posedge pclk);
        rx_char <= ch;
        rx_parity_bit <= (^ch) ^ bad;
        rx_char_valid <= 1'b1;
        @(posedge pclk);
        rx_char_valid <= 1'b0;
        cyc(2);
    endtask : rxc

    task automatic guard(input logic exp);
        @(posedge pclk);
        tx_guard_sample <= 1'b1;
        @(posedge pclk);
        tx_guard_sample <= 1'b0;
        @(negedge pclk);
        chk(32'(tx_repeat), 32'(exp));
    endtask : guard

    // read-data monitor: oldest note against each completed read
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = expq.pop_front();
            chk({31'h0, pslverr}, {31'h0, e[64]});
            chk(prdata & e[63:32], e[31:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, card_low, shared} = 7'h0;
        {paddr, pwdata, bit_tick, tx_busy, tx_guard_sample} = '0;
        {rx_char_valid, rx_char, rx_parity_bit} = '0;
        {cts_pin, dcd_pin, dsr_pin, ri_pin, tx_serial, tx_empty} = 6'h3f;
        void'($urandom(32'hfc82));
        tx_char = 8'($urandom());
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(32'({txd_o, rts_o, dtr_o, rx_enable, tx_enable}), 32'h1f);
        apb(1'b0, line_mode_pkg::ADDR_RATIO, 32'h0000_0174, '1, 1'b0);
        apb(1'b0, 8'h3c, 32'h0000_0000, '1, 1'b1);
        wr(line_mode_pkg::ADDR_RATIO, 32'h0000_0010);
        wr(line_mode_pkg::ADDR_IRFILT, 32'h0000_0004);
        // channel test modes
        mode(4'h0, 2'd2, 1'b0, 3'd0);
        tx_serial <= 1'b0;
        cyc(3);
        chk(32'({rx_serial, txd_o}), 32'h1);
        tx_serial <= 1'b1;
        card_low <= 1'b1;
        mode(4'h0, 2'd1, 1'b0, 3'd0);
        chk(32'({txd_o, rx_serial, rx_enable}), 32'h1);
        mode(4'h0, 2'd3, 1'b0, 3'd0);
        chk(32'({txd_o, rx_enable, tx_enable}), 32'h0);
        card_low <= 1'b0;
        // rs485 and modem lines
        mode(line_mode_pkg::LINE_RS485, 2'd0, 1'b0, 3'd0);
        tx_empty <= 1'b0;
        cyc(3);
        chk(32'(rts_o), 32'h1);
        tx_empty <= 1'b1;
        cyc(3);
        chk(32'(rts_o), 32'h0);
        mode(line_mode_pkg::LINE_MODEM, 2'd0, 1'b0, 3'd0);
        chk(32'(rts_o), 32'h0);
        wr(A_CTL, 32'h0000_0008);
        chk(32'(dtr_o), 32'h0);
        wr(A_CTL, 32'h0000_000c);
        chk(32'(dtr_o), 32'h1);
        apb(1'b0, A_ST, 32'h0000_0000, 32'h0000_0f00, 1'b0);
        {cts_pin, ri_pin} <= 2'b00;
        cyc(6);
        apb(1'b0, A_ST, 32'h0000_0900, 32'h0000_0f00, 1'b0);
        apb(1'b0, A_ST, 32'h0000_0000, 32'h0000_0f00, 1'b0);
        tx_busy <= 1'b1;
        {cts_pin, ri_pin} <= 2'b11;
        cyc(6);
        chk(32'(tx_enable), 32'h1);
        tx_busy <= 1'b0;
        cyc(4);
        chk(32'(tx_enable), 32'h0);
        // smart card receive
        c = 8'($urandom());
        shared <= 1'b1;
        mode(line_mode_pkg::LINE_ISO_T0, 2'd0, 1'b1, 3'd0);
        rxc(c, 1'b1);
        pulse_tick();
        cyc(3);
        chk(32'(txd_o), 32'h1);
        apb(1'b0, A_ST, 32'h0000_0004, 32'h0000_0005, 1'b0);
        apb(1'b0, line_mode_pkg::ADDR_HOLD, 32'(c), '1, 1'b0);
        wr(A_CTL, 32'h0000_0001);
        apb(1'b0, A_ST, 32'h0000_0000, 32'h0000_0004, 1'b0);
        mode(line_mode_pkg::LINE_ISO_T0, 2'd0, 1'b0, 3'd0);
        rxc(c, 1'b1);
        pulse_tick();
        seen = 1'b0;
        repeat (6) begin
            @(negedge pclk);
            seen = seen | (!txd_o && txd_oe);
        end
        chk(32'(seen), 32'h1);
        pulse_tick();
        mode(line_mode_pkg::LINE_ISO_T1, 2'd0, 1'b0, 3'd0);
        wr(A_CTL, 32'h0000_0010);
        rxc(c, 1'b1);
        apb(1'b0, A_ST, 32'h0000_0003, 32'h0000_0003, 1'b0);
        chk(32'(tx_parity), 32'(^tx_char));
        // character repetition with limit 2
        mode(line_mode_pkg::LINE_ISO_T0, 2'd0, 1'b0, 3'd2);
        card_low <= 1'b1;
        cyc(6);
        guard(1'b1);
        card_low <= 1'b0;
        cyc(6);
        guard(1'b0);
        card_low <= 1'b1;
        cyc(6);
        guard(1'b1);
        guard(1'b1);
        guard(1'b0);
        apb(1'b0, A_ST, 32'h0000_0008, 32'h0000_0008, 1'b0);
        wr(A_CTL, 32'h0000_0002);
        apb(1'b0, A_ST, 32'h0000_0000, 32'h0000_0008, 1'b0);
        card_low <= 1'b0;
        // successive nack limit of one: second bad char accepted
        apb(1'b0, line_mode_pkg::ADDR_HOLD, 32'(c), '1, 1'b0);
        wr(A_MODE, {21'h0, 3'd1, 1'b1, 1'b0, 2'd0,
            line_mode_pkg::LINE_ISO_T0});
        rxc(c, 1'b1);
        pulse_tick();
        pulse_tick();
        apb(1'b0, A_ST, 32'h0000_0000, 32'h0000_0009, 1'b0);
        rxc(c, 1'b1);
        apb(1'b0, A_ST, 32'h0000_0009, 32'h0000_0009, 1'b0);
        // infrared: own pins; modulator pulse, then filter value 4
        shared <= 1'b0;
        mode(line_mode_pkg::LINE_IR, 2'd0, 1'b0, 3'd0);
        tx_serial <= 1'b0;
        pulse_tick();
        tx_serial <= 1'b1;
        k = 0;
        repeat (10) begin
            @(posedge pclk);
            k += int'(txd_o);
        end
        chk(32'(k), 32'(IR_PULSE));
        card_low <= 1'b1;
        cyc(14);
        chk(32'(rx_serial), 32'h0);
        card_low <= 1'b0;
        cyc(30);
        // low long enough to pass the synchroniser, short of the filter
        card_low <= 1'b1;
        cyc(3);
        card_low <= 1'b0;
        cyc(12);
        chk(32'(rx_serial), 32'h1);
        cyc(2);
        finish_test();
    end
endmodule : tb_usart_line_mode
`default_nettype wire
